// >>> common/timer_pkg.sv
package timer_pkg;
  // ----------------------------------------------------------------
  // Bus geometry and register indices (byte address = 4 * index).
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [5:0] HI_IDX [2] = '{6'h0C, 6'h0F};
  localparam logic [5:0] LO_IDX [2] = '{6'h0D, 6'h10};
  localparam logic [5:0] CTL_IDX [2] = '{6'h0E, 6'h11};
  localparam logic [5:0] T3_CTL_IDX = 6'h25;
  localparam logic [5:0] IRQ_CTL_IDX = 6'h30;
  localparam logic [5:0] IRQ_CTL2_IDX = 6'h31;
  localparam logic [5:0] T3_CNT_IDX = 6'h32;
  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int EDGE_BIT = 3;
  localparam int RUN_BIT = 4;
  localparam int MODE_LSB = 6;
  localparam int C0_EN_BIT = 2;
  localparam int C1_EN_BIT = 3;
  localparam int C0_FLAG_BIT = 5;
  localparam int C1_FLAG_BIT = 6;
  localparam int T3_EN_BIT = 1;
  localparam int T3_FLAG_BIT = 5;
  // ----------------------------------------------------------------
  // Mode encodings and interrupt vectors.
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_UNUSED = 2'h0;
  localparam logic [1:0] MODE_EVENT = 2'h1;
  localparam logic [1:0] MODE_TIMER = 2'h2;
  localparam logic [1:0] MODE_PULSE = 2'h3;
  localparam logic [7:0] VEC_C0 = 8'h08;
  localparam logic [7:0] VEC_C1 = 8'h0C;
  localparam logic [7:0] VEC_T3 = 8'h14;
  // ----------------------------------------------------------------
  // Timing and reset values.
  // ----------------------------------------------------------------
  localparam int MCLK_PERIOD_NS = 10;
  localparam int INSTR_PERIOD_NS = 40;
  localparam int INSTR_DIV = INSTR_PERIOD_NS / MCLK_PERIOD_NS;
  localparam logic [1:0] INSTR_DIV_LAST = 2'(INSTR_DIV - 1);
  localparam logic [15:0] CNT16_RESET = 16'h0000;
  localparam logic [15:0] CNT16_MAX = 16'hFFFF;
  localparam logic [7:0] CNT8_RESET = 8'h00;
  localparam logic [7:0] CNT8_MAX = 8'hFF;
  localparam logic [6:0] PRESCALE_RESET = 7'h00;
endpackage

// >>> design/dual_event_timer.sv
module dual_event_timer (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [timer_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_counter0_input_pin,
  input wire logic i_counter1_input_pin,
  output logic o_irq,
  output logic [7:0] o_irq_vector,
  output logic o_wake
);
  import timer_pkg::*;

  // ----------------------------------------------------------------
  // Helper functions.
  // ----------------------------------------------------------------
  // Edge on a synchronised pin: falling when sel is set, rising otherwise.
  function automatic logic active_edge(input logic prev, input logic cur, input logic sel);
    return sel ? (prev & ~cur) : (~prev & cur);
  endfunction

  // Mask of prescaler bits that must all be one for a divided tick.
  function automatic logic [6:0] prescale_mask(input logic [2:0] sel);
    logic [7:0] m;
    m = (8'h01 << sel) - 8'h01;
    return m[6:0];
  endfunction

  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  logic [1:0] pin_meta_ff, pin_sync_ff, pin_prev_ff;
  logic [1:0] div_ff;
  logic instr_tick;
  logic [15:0] cnt_ff [2];
  logic [15:0] preload_ff [2];
  logic [7:0] low_buf_ff [2];
  logic [1:0] mode_ff [2];
  logic [1:0] run_ff, edge_sel_ff, pw_busy_ff;
  logic [1:0] wr_hi, wr_lo, wr_ctl, rd_hi, hold_clk;
  logic [1:0] ev_edge, back_edge, pw_start, pw_end, inc, ovf;
  logic [7:0] t3_cnt_ff, t3_preload_ff;
  logic [2:0] t3_psel_ff;
  logic t3_run_ff, t3_edge_sel_ff;
  logic [6:0] prescale_ff;
  logic t3_tick, t3_inc, t3_ovf;
  logic c0_flag_ff, c1_flag_ff, t3_flag_ff;
  logic c0_en_ff, c1_en_ff, t3_en_ff;
  logic req, acc, wr, rd;
  logic [5:0] idx;
  logic [7:0] wd, rd_mux;

  // ----------------------------------------------------------------
  // Bus access decode.
  // ----------------------------------------------------------------
  // An access takes effect at the edge where waitrequest is sampled low.
  // Only byte lane 0 is mapped, so a write with that lane off is dropped.
  assign req = i_avs_read | i_avs_write;
  assign acc = req & ~o_avs_waitrequest;
  assign wr = acc & i_avs_write & i_avs_byteenable[0];
  assign rd = acc & i_avs_read;
  assign idx = i_avs_address[7:2];
  assign wd = i_avs_writedata[7:0];

  // Per-counter strobes; the clock hold covers the whole pending high read.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      wr_hi[i] = wr & (idx == HI_IDX[i]);
      wr_lo[i] = wr & (idx == LO_IDX[i]);
      wr_ctl[i] = wr & (idx == CTL_IDX[i]);
      rd_hi[i] = rd & (idx == HI_IDX[i]);
      hold_clk[i] = i_avs_read & (idx == HI_IDX[i]);
    end
  end

  // ----------------------------------------------------------------
  // Bus handshake.
  // ----------------------------------------------------------------
  // One wait cycle per request keeps the read mux registered.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_avs_waitrequest <= 1'b1;
    end else if (req && o_avs_waitrequest) begin
      o_avs_waitrequest <= 1'b0;
    end else begin
      o_avs_waitrequest <= 1'b1;
    end
  end

  // Read mux; unused control bits read as zero except timer 3 bits 7:6, which read MODE_TIMER; unmapped addresses read as zero.
  always_comb begin
    rd_mux = 8'h00;
    if (idx == HI_IDX[0]) begin
      rd_mux = cnt_ff[0][15:8];
    end else if (idx == LO_IDX[0]) begin
      rd_mux = low_buf_ff[0];
    end else if (idx == CTL_IDX[0]) begin
      rd_mux = {mode_ff[0], 1'b0, run_ff[0], edge_sel_ff[0], 3'h0};
    end else if (idx == HI_IDX[1]) begin
      rd_mux = cnt_ff[1][15:8];
    end else if (idx == LO_IDX[1]) begin
      rd_mux = low_buf_ff[1];
    end else if (idx == CTL_IDX[1]) begin
      rd_mux = {mode_ff[1], 1'b0, run_ff[1], edge_sel_ff[1], 3'h0};
    end else if (idx == T3_CTL_IDX) begin
      rd_mux = {MODE_TIMER, 1'b0, t3_run_ff, t3_edge_sel_ff, t3_psel_ff};
    end else if (idx == T3_CNT_IDX) begin
      rd_mux = t3_cnt_ff;
    end else if (idx == IRQ_CTL_IDX) begin
      rd_mux = {1'b0, c1_flag_ff, c0_flag_ff, 1'b0, c1_en_ff, c0_en_ff, 2'h0};
    end else if (idx == IRQ_CTL2_IDX) begin
      rd_mux = {2'h0, t3_flag_ff, 3'h0, t3_en_ff, 1'b0};
    end
  end

  // Read data is captured one edge before the master samples it.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && o_avs_waitrequest) begin
      o_avs_readdata <= {24'h00_0000, rd_mux};
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and instruction clock divider.
  // ----------------------------------------------------------------
  // Pins are asynchronous; edges are taken only after the second stage.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      pin_meta_ff <= 2'h0;
      pin_sync_ff <= 2'h0;
      pin_prev_ff <= 2'h0;
    end else begin
      pin_meta_ff <= {i_counter1_input_pin, i_counter0_input_pin};
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
    end
  end

  // The instruction clock is a one-cycle enable every fourth master clock.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      div_ff <= 2'h0;
    end else begin
      div_ff <= instr_tick ? 2'h0 : div_ff + 2'h1;
    end
  end
  assign instr_tick = (div_ff == INSTR_DIV_LAST);

  // ----------------------------------------------------------------
  // Count enables for counters 0 and 1.
  // ----------------------------------------------------------------
  // Pulse mode reacts to transitions only, so a level already present
  // when run is set does not start a measurement.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      ev_edge[i] = active_edge(pin_prev_ff[i], pin_sync_ff[i], edge_sel_ff[i]);
      back_edge[i] = active_edge(pin_prev_ff[i], pin_sync_ff[i], ~edge_sel_ff[i]);
      pw_start[i] = run_ff[i] & (mode_ff[i] == MODE_PULSE) & ~pw_busy_ff[i] & ev_edge[i];
      pw_end[i] = pw_busy_ff[i] & back_edge[i];
      inc[i] = 1'b0;
      if (run_ff[i] && !hold_clk[i]) begin
        case (mode_ff[i])
          MODE_EVENT: inc[i] = ev_edge[i];
          MODE_TIMER: inc[i] = instr_tick;
          MODE_PULSE: inc[i] = pw_busy_ff[i] & instr_tick;
          default: inc[i] = 1'b0;
        endcase
      end
      ovf[i] = inc[i] & (cnt_ff[i] == CNT16_MAX);
    end
  end

  // ----------------------------------------------------------------
  // Counters 0 and 1: buffer, preload, control and count.
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      for (int i = 0; i < 2; i++) begin
        cnt_ff[i] <= CNT16_RESET;
        preload_ff[i] <= CNT16_RESET;
        low_buf_ff[i] <= CNT8_RESET;
        mode_ff[i] <= MODE_UNUSED;
      end
      run_ff <= 2'h0;
      edge_sel_ff <= 2'h0;
      pw_busy_ff <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        // Low byte buffer: filled by software or by a high byte read.
        if (wr_lo[i]) begin
          low_buf_ff[i] <= wd;
        end else if (rd_hi[i]) begin
          low_buf_ff[i] <= cnt_ff[i][7:0];
        end
        // Only a high byte write touches the preload.
        if (wr_hi[i]) begin
          preload_ff[i] <= {wd, low_buf_ff[i]};
        end
        // Control: software always wins; hardware clears run only in pulse mode.
        if (wr_ctl[i]) begin
          edge_sel_ff[i] <= wd[EDGE_BIT];
          run_ff[i] <= wd[RUN_BIT];
          mode_ff[i] <= wd[MODE_LSB+:2];
        end else if (pw_end[i]) begin
          run_ff[i] <= 1'b0;
        end
        // Pulse tracker: one measurement per arming, result then held.
        if (!run_ff[i] || mode_ff[i] != MODE_PULSE || pw_end[i]) begin
          pw_busy_ff[i] <= 1'b0;
        end else if (pw_start[i]) begin
          pw_busy_ff[i] <= 1'b1;
        end
        // Count: load while stopped, otherwise wrap to preload.
        if (wr_hi[i] && !run_ff[i]) begin
          cnt_ff[i] <= {wd, low_buf_ff[i]};
        end else if (ovf[i]) begin
          cnt_ff[i] <= preload_ff[i];
        end else if (inc[i]) begin
          cnt_ff[i] <= cnt_ff[i] + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Timer 3 with prescaler.
  // ----------------------------------------------------------------
  // The prescaler free-runs on the instruction clock; a ratio change
  // takes effect at once, so the first divided period may be short.
  assign t3_tick = instr_tick & ((prescale_ff & prescale_mask(t3_psel_ff)) == prescale_mask(t3_psel_ff));
  assign t3_inc = t3_run_ff & t3_tick;
  assign t3_ovf = t3_inc & (t3_cnt_ff == CNT8_MAX);

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      prescale_ff <= PRESCALE_RESET;
    end else if (instr_tick) begin
      prescale_ff <= prescale_ff + 7'h01;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      t3_cnt_ff <= CNT8_RESET;
      t3_preload_ff <= CNT8_RESET;
      t3_psel_ff <= 3'h0;
      t3_run_ff <= 1'b0;
      t3_edge_sel_ff <= 1'b0;
    end else begin
      if (wr && idx == T3_CTL_IDX) begin
        t3_psel_ff <= wd[2:0];
        t3_edge_sel_ff <= wd[EDGE_BIT];
        t3_run_ff <= wd[RUN_BIT];
      end
      // A write to the count index sets the preload; a stopped timer takes the value at once.
      if (wr && idx == T3_CNT_IDX) begin
        t3_preload_ff <= wd;
      end
      if (wr && idx == T3_CNT_IDX && !t3_run_ff) begin
        t3_cnt_ff <= wd;
      end else if (t3_ovf) begin
        t3_cnt_ff <= t3_preload_ff;
      end else if (t3_inc) begin
        t3_cnt_ff <= t3_cnt_ff + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flags and enables.
  // ----------------------------------------------------------------
  // A hardware set in the same cycle as a software clear wins.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      c0_flag_ff <= 1'b0;
      c1_flag_ff <= 1'b0;
      t3_flag_ff <= 1'b0;
      c0_en_ff <= 1'b0;
      c1_en_ff <= 1'b0;
      t3_en_ff <= 1'b0;
    end else begin
      if (wr && idx == IRQ_CTL_IDX) begin
        c0_en_ff <= wd[C0_EN_BIT];
        c1_en_ff <= wd[C1_EN_BIT];
      end
      if (wr && idx == IRQ_CTL2_IDX) begin
        t3_en_ff <= wd[T3_EN_BIT];
      end
      c0_flag_ff <= ovf[0] | ((wr && idx == IRQ_CTL_IDX) ? wd[C0_FLAG_BIT] : c0_flag_ff);
      c1_flag_ff <= ovf[1] | ((wr && idx == IRQ_CTL_IDX) ? wd[C1_FLAG_BIT] : c1_flag_ff);
      t3_flag_ff <= t3_ovf | ((wr && idx == IRQ_CTL2_IDX) ? wd[T3_FLAG_BIT] : t3_flag_ff);
    end
  end

  // Request and vector by fixed priority; enables gate in every mode.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_irq <= 1'b0;
      o_irq_vector <= 8'h00;
    end else begin
      o_irq <= (c0_flag_ff & c0_en_ff) | (c1_flag_ff & c1_en_ff) | (t3_flag_ff & t3_en_ff);
      if (c0_flag_ff && c0_en_ff) begin
        o_irq_vector <= VEC_C0;
      end else if (c1_flag_ff && c1_en_ff) begin
        o_irq_vector <= VEC_C1;
      end else if (t3_flag_ff && t3_en_ff) begin
        o_irq_vector <= VEC_T3;
      end else begin
        o_irq_vector <= 8'h00;
      end
    end
  end

  // Wake pulse on any overflow, regardless of interrupt enables.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_wake <= 1'b0;
    end else begin
      o_wake <= ovf[0] | ovf[1] | t3_ovf;
    end
  end

  // ----------------------------------------------------------------
  // Assertions and cover points.
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  // Properties watch internal strobes, so a slip on the bus side cannot mask a fault.

  a_tick_spacing: assert property (instr_tick |=> !instr_tick [*3] ##1 instr_tick)
    else $error("instruction tick not every fourth clock");
  a_lo_keeps_preload: assert property (wr_lo[0] |=> $stable(preload_ff[0]))
    else $error("low byte write changed preload");
  a_hi_loads_preload: assert property (wr_hi[0] |=> preload_ff[0] == {$past(wd), $past(low_buf_ff[0])})
    else $error("high byte write did not load preload");
  a_hi_read_latch: assert property (rd_hi[1] |=> low_buf_ff[1] == $past(cnt_ff[1][7:0]))
    else $error("high byte read did not latch low byte");
  a_ovf_reload: assert property (ovf[0] |=> cnt_ff[0] == $past(preload_ff[0]))
    else $error("overflow did not reload counter");
  a_ovf_flag_set: assert property (ovf[1] |=> c1_flag_ff)
    else $error("overflow did not set flag");
  a_pulse_done_stops: assert property (pw_end[0] && !wr_ctl[0] |=> !run_ff[0] && !pw_busy_ff[0])
    else $error("pulse end did not clear run");
  a_run_held_timer: assert property (run_ff[0] && mode_ff[0] != MODE_PULSE && !wr_ctl[0] |=> run_ff[0])
    else $error("run cleared by hardware outside pulse mode");
  a_wake_on_ovf: assert property ((ovf[0] || ovf[1] || t3_ovf) |=> o_wake)
    else $error("overflow gave no wake pulse");
  a_irq_masked: assert property (!c0_en_ff && !c1_en_ff && !t3_en_ff |=> !o_irq)
    else $error("interrupt raised while all enables clear");
  a_off_load_counter: assert property (wr_hi[0] && !run_ff[0] |=> cnt_ff[0] == preload_ff[0])
    else $error("stopped counter not loaded by preload write");
  a_hi_read_hold: assert property (hold_clk[1] && !wr_hi[1] |=> $stable(cnt_ff[1]))
    else $error("counter moved during high byte read");
  a_bus_answer: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  // Timer 3 reloads and flags in the same way as the 16-bit counters.
  a_t3_ovf_reload: assert property (t3_ovf |=> t3_cnt_ff == $past(t3_preload_ff))
    else $error("timer 3 overflow did not reload");
  a_t3_flag_set: assert property (t3_ovf |=> t3_flag_ff)
    else $error("timer 3 overflow did not set flag");

  // Covers mark the main scenarios the bench is meant to reach.
  c_c0_overflow: cover property (ovf[0] ##1 o_irq);
  c_pulse_measured: cover property (pw_start[0] ##[1:1000] pw_end[0]);
  c_t3_overflow: cover property (t3_ovf && t3_psel_ff != 3'h0);
  c_event_counted: cover property (mode_ff[1] == MODE_EVENT && inc[1]);
  c_irq_priority: cover property (c0_flag_ff && c0_en_ff && t3_flag_ff && t3_en_ff);
endmodule

// >>> testbench/pin_driver.sv
module pin_driver (
  input wire logic i_mclk,
  output logic o_counter0_input_pin,
  output logic o_counter1_input_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // External pulse source on the two counter pins.
  // ------------------------------------------------------------
  initial begin
    o_counter0_input_pin = 1'b0;
    o_counter1_input_pin = 1'b0;
  end

  // One high pulse then a low gap, both held whole clocks so the synchroniser sees each edge.
  task automatic pulse(input int which, input int hi, input int lo);
    @(posedge i_mclk);
    if (which == 0) o_counter0_input_pin <= 1'b1;
    else o_counter1_input_pin <= 1'b1;
    repeat (hi) @(posedge i_mclk);
    if (which == 0) o_counter0_input_pin <= 1'b0;
    else o_counter1_input_pin <= 1'b0;
    repeat (lo) @(posedge i_mclk);
  endtask
endmodule

// >>> testbench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import timer_pkg::*;
  typedef struct {logic [5:0] idx; logic [31:0] val;} note_t;
  // ------------------------------------------------------------
  // Stimulus, design and far-side pins.
  // ------------------------------------------------------------
  logic i_mclk = 1'b0;
  logic i_resetn = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic wake;
  logic [7:0] irq_vector;
  logic pin0;
  logic pin1;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int wakes = 0;
  int n;
  note_t notes[$];
  logic [7:0] rnd = 8'h44;

  always #5 i_mclk = ~i_mclk;

  dual_event_timer u_dual_event_timer (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_avs_address(avs_address),
    .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_byteenable(4'hF), .i_avs_writedata(avs_writedata),
    .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest), .i_counter0_input_pin(pin0),
    .i_counter1_input_pin(pin1), .o_irq(irq), .o_irq_vector(irq_vector), .o_wake(wake));
  pin_driver u_pin_driver (.i_mclk(i_mclk), .o_counter0_input_pin(pin0), .o_counter1_input_pin(pin1));

  // ------------------------------------------------------------
  // Helpers.
  // ------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task results;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // The request is held until waitrequest is sampled low, then released at that same edge.
  task automatic access(input logic wr, input logic [5:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge i_mclk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge i_mclk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    if (k >= 20) chk("waitrequest", 32'h0, 32'h1);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    access(1'b1, idx, d);
  endtask

  // The expected byte is noted first; the monitor compares it when the read completes.
  task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
    notes.push_back('{idx, {24'h0, exp}});
    access(1'b0, idx, 8'h00);
  endtask

  // Overflow reaches irq a cycle after the flag; the bound of 60 clocks covers 15 instruction ticks.
  task automatic wait_irq;
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 60) begin
      @(posedge i_mclk);
      k++;
    end
    chk("irq", 32'h1, {31'h0, irq});
  endtask

  // ------------------------------------------------------------
  // Monitor: read results, wake pulses and the run ceiling.
  // ------------------------------------------------------------
  always @(posedge i_mclk) begin
    cycles++;
    if (wake === 1'b1) wakes <= wakes + 1; // Non-blocking, so the main sequence reads it race free.
    if (cycles > 20000) begin
      err_count++;
      results();
    end
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && notes.size() > 0) begin
      chk($sformatf("readdata %h", notes[0].idx), notes[0].val, avs_readdata);
      notes.pop_front();
    end
  end

  // ------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge i_mclk);
    chk("waitrequest", 32'h1, {31'h0, avs_waitrequest});
    i_resetn <= 1'b1;
    rd(CTL_IDX[0], 8'h00);
    rd(CTL_IDX[1], 8'h00);
    rd(IRQ_CTL_IDX, 8'h00);
    rd(T3_CTL_IDX, 8'h80);
    rd(6'h3F, 8'h00);
    wr(CTL_IDX[0], 8'h2F);
    rd(CTL_IDX[0], 8'h08);
    wr(CTL_IDX[0], 8'h00);
    wr(T3_CTL_IDX, 8'hEF);
    rd(T3_CTL_IDX, 8'h8F);
    for (int c = 0; c < 2; c++) begin
      wr(LO_IDX[c], 8'h34);
      rd(HI_IDX[c], 8'h00);
      rd(LO_IDX[c], 8'h00);
      wr(LO_IDX[c], 8'hFE);
      wr(HI_IDX[c], 8'hFF);
      rd(HI_IDX[c], 8'hFF);
      rd(LO_IDX[c], 8'hFE);
    end
    // Timer mode: FFFE climbs to FFFF, overflows and reloads FFFE.
    for (int c = 0; c < 2; c++) begin
      wr(IRQ_CTL_IDX, c ? 8'h08 : 8'h04);
      wr(CTL_IDX[c], 8'h90);
      wait_irq();
      chk("vector", c ? 32'h0C : 32'h08, {24'h0, irq_vector});
      rd(CTL_IDX[c], 8'h90);
      wr(CTL_IDX[c], 8'h80);
      rd(IRQ_CTL_IDX, c ? 8'h48 : 8'h24);
      rd(HI_IDX[c], 8'hFF);
      wr(IRQ_CTL_IDX, 8'h00);
    end
    chk("wake", 32'h1, {31'h0, wakes >= 2});
    // Event mode on falling edges, a random number of pulses.
    wr(LO_IDX[1], 8'h00);
    wr(HI_IDX[1], 8'h00);
    wr(CTL_IDX[1], 8'h58);
    rnd = lfsr(rnd);
    n = rnd[2:0] + 1;
    for (int i = 0; i < n; i++) begin
      rnd = lfsr(rnd);
      u_pin_driver.pulse(1, 3 + rnd[1:0], 3 + rnd[3:2]);
    end
    repeat (8) @(posedge i_mclk);
    wr(CTL_IDX[1], 8'h40);
    rd(HI_IDX[1], 8'h00);
    rd(LO_IDX[1], 8'(n));
    // Pulse mode, rising start: 40 clocks are 10 instruction ticks.
    wr(LO_IDX[0], 8'h00);
    wr(HI_IDX[0], 8'h00);
    wr(CTL_IDX[0], 8'hD0);
    u_pin_driver.pulse(0, 40, 12);
    rd(CTL_IDX[0], 8'hC0);
    u_pin_driver.pulse(0, 20, 12);
    rd(HI_IDX[0], 8'h00);
    rd(LO_IDX[0], 8'h0A);
    // Timer 3 overflow, then priority and masking of flags.
    // Ratio 1:2 gives a tick every 8 clocks; FE to overflow is 2 ticks, so 10 wakes per 160 clocks.
    wr(T3_CNT_IDX, 8'hFE);
    wr(IRQ_CTL2_IDX, 8'h02);
    wr(T3_CTL_IDX, 8'h91);
    wait_irq();
    chk("vector", 32'h14, {24'h0, irq_vector});
    n = wakes;
    repeat (160) @(posedge i_mclk);
    chk("t3 wakes", 32'h0A, wakes - n);
    wr(T3_CTL_IDX, 8'h80);
    rd(IRQ_CTL2_IDX, 8'h22);
    wr(IRQ_CTL_IDX, 8'h20);
    repeat (3) @(posedge i_mclk);
    chk("vector", 32'h14, {24'h0, irq_vector});
    wr(IRQ_CTL_IDX, 8'h24);
    repeat (3) @(posedge i_mclk);
    chk("vector", 32'h08, {24'h0, irq_vector});
    wr(IRQ_CTL_IDX, 8'h00);
    wr(IRQ_CTL2_IDX, 8'h20);
    repeat (3) @(posedge i_mclk);
    chk("irq", 32'h0, {31'h0, irq});
    @(posedge i_mclk);
    chk("notes left", 32'h0, notes.size());
    results();
  end
endmodule
